// >>> common/pcc_cfg.svh
// register offsets, field positions, reset values and codes of the clock
// configuration block; included by the top design module alone, by bare name
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define PCC_IDX_SLOW_OSC_TRIM    8'h3c
`define PCC_IDX_PLL_CONTROL      8'h3d
`define PCC_IDX_PLL_OUT_DIVIDER  8'h3e
`define PCC_IDX_STATUS           8'h30

// pll control fields
`define PCC_SEL_MSB              7
`define PCC_SEL_LSB              4
`define PCC_EN_BIT               3
`define PCC_PD_BIT               2
`define PCC_FB_MSB               1
`define PCC_FB_LSB               0

// reset values
`define PCC_RST_TRIM             8'h80
`define PCC_RST_PLL_CONTROL      8'h04
`define PCC_RST_OUT_DIVIDER      8'h08

// clock pin source codes
`define PCC_SRC_GPIO             4'h0
`define PCC_SRC_PLL              4'h1
`define PCC_SRC_LOW              4'h2
`define PCC_SRC_HIGH             4'h3
`define PCC_SRC_XTAL             4'h4
`define PCC_SRC_XTAL_DIV2        4'h5
`define PCC_SRC_XTAL_DIV4        4'h6
`define PCC_SRC_XTAL_DIV8        4'h7
`define PCC_SRC_TIMER_ZERO       4'h8
`define PCC_SRC_TIMER_THREE      4'hb

// feedback multiplication factors
`define PCC_FB_MULT_00           5'h17
`define PCC_FB_MULT_01           5'h1b
`define PCC_FB_MULT_10           5'h1c
`define PCC_FB_MULT_11           5'h17

// legal output divider range
`define PCC_DIV_MIN              8'h08
`define PCC_DIV_MAX              8'hfe

`endif

// >>> common/pcc_pkg.sv
// types shared by the clock configuration block
// assumes pcc_cfg.svh carries the numeric constants
package pcc_pkg;
  typedef logic [7:0] pcc_byte_t;   // one register byte
  typedef logic [3:0] pcc_sel_t;    // clock pin source code
  typedef logic [4:0] pcc_mult_t;   // feedback multiplication factor
endpackage

// >>> tb/pcc_clock_config_monitor.sv
// checker of the clock configuration block, bound to its top module
// assumes it sees the top module's ports only
`timescale 1ns/1ps
module pcc_clock_config_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // pin and pll
  input wire logic [3:0]  timer_overflow_i,
  input wire logic        gpio_drive_i,
  input wire logic        clock_output_pin_i,
  input wire logic        pll_power_down_o,
  input wire logic [4:0]  feedback_mult_o,
  input wire logic [7:0]  output_divide_factor_o,
  input wire logic        gpio_in_o,
  input wire logic        clock_output_pin_o,
  input wire logic        clock_output_pin_oe_n_o
);
  logic [7:0] ctrl;    // shadow of the control register
  logic [7:0] ctrl_q;  // shadow one cycle late
  logic       rst_q;   // reset one cycle late
  logic       wr_c;    // accepted control write
  logic       wr_d;    // accepted divider write
  logic       steady;  // control settled
  logic [3:0] code;    // pin source code
  assign wr_c = cyc_i && stb_i && we_i && ack_o && sel_i[0]
                && adr_i[9:2] == 8'h3d;
  assign wr_d = cyc_i && stb_i && we_i && ack_o && sel_i[0]
                && adr_i[9:2] == 8'h3e;
  assign steady = ctrl == ctrl_q && !rst_q;
  assign code = ctrl[7:4];

  // shadow follows accepted control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 8'h04;
    end else if (wr_c) begin
      ctrl <= dat_i[7:0];
    end
  end
  // delayed copies
  always_ff @(posedge clk_i) begin
    ctrl_q <= ctrl;
    rst_q <= rst_i;
  end

  // feedback factor of a code
  function automatic logic [4:0] fbm(input logic [1:0] c);
    case (c)
      2'h1: return 5'h1b;
      2'h2: return 5'h1c;
      default: return 5'h17;
    endcase
  endfunction

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack;
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_fb;
    wr_c |=> feedback_mult_o == fbm($past(dat_i[1:0]));
  endproperty
  a_fb: assert property (p_fb) else $error("feedback factor wrong");
  property p_pd;
    wr_c |=> pll_power_down_o == $past(dat_i[2]);
  endproperty
  a_pd: assert property (p_pd) else $error("power down wrong");
  property p_div;
    wr_d |=> output_divide_factor_o == $past(dat_i[7:0]);
  endproperty
  a_div: assert property (p_div) else $error("divider wrong");
  property p_low;
    steady && code == 4'h2 |-> !clock_output_pin_o
      && !clock_output_pin_oe_n_o;
  endproperty
  a_low: assert property (p_low) else $error("pin not low");
  property p_high;
    steady && code == 4'h3 |-> clock_output_pin_o
      && !clock_output_pin_oe_n_o;
  endproperty
  a_high: assert property (p_high) else $error("pin not high");
  property p_io;
    steady && code == 4'h0 |-> clock_output_pin_oe_n_o == !$past(gpio_drive_i);
  endproperty
  a_io: assert property (p_io) else $error("io drive wrong");
  property p_in;
    !rst_q |-> gpio_in_o == $past(clock_output_pin_i);
  endproperty
  a_in: assert property (p_in) else $error("io input wrong");
  property p_off;
    steady && !ctrl[3] && (code == 4'h1 || (code >= 4'h4 && code <= 4'hb))
      |-> !clock_output_pin_o;
  endproperty
  a_off: assert property (p_off) else $error("clock while disabled");
  property p_rsv;
    steady && code >= 4'hc |-> !clock_output_pin_o;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved not static");
  property p_tmr;
    steady && ctrl[3] && code[3:2] == 2'h2 && timer_overflow_i[code[1:0]]
      |-> ##2 clock_output_pin_o != $past(clock_output_pin_o, 2);
  endproperty
  a_tmr: assert property (p_tmr) else $error("no timer toggle");
endmodule

bind pcc_clock_config pcc_clock_config_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .timer_overflow_i(timer_overflow_i), .gpio_drive_i(gpio_drive_i),
  .clock_output_pin_i(clock_output_pin_i),
  .pll_power_down_o(pll_power_down_o), .feedback_mult_o(feedback_mult_o),
  .output_divide_factor_o(output_divide_factor_o), .gpio_in_o(gpio_in_o),
  .clock_output_pin_o(clock_output_pin_o),
  .clock_output_pin_oe_n_o(clock_output_pin_oe_n_o));

// >>> tb/pcc_pin_load.sv
// load on the clock output pin: logic clocked from the pin itself
// assumes oe_n_i low means the device drives the pin; no pull on the line
`timescale 1ns/1ps
module pcc_pin_load (
  // clock and control
  input  wire logic clk_i,
  input  wire logic clr_i,
  // pin
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  output logic      line_o,
  // rising edges seen while driven
  output int        edges_o
);
  logic flt = 1'b0;  // changing level of an undriven line

  // an undriven line must not hold its last value
  always_ff @(posedge clk_i) begin
    flt <= ~flt;
  end
  assign line_o = oe_n_i ? flt : pin_i;

  // edge counter clocked from the pin
  initial edges_o = 0;
  always @(posedge line_o or posedge clr_i) begin
    if (clr_i) begin
      edges_o <= 0;
    end else if (!oe_n_i) begin
      edges_o <= edges_o + 1;
    end
  end
endmodule

// >>> tb/pll_clock_output_config_tb.sv
// testbench of the clock configuration block
// assumes the design, the monitor and the pin load are compiled first
`timescale 1ns/1ps
module pll_clock_output_config_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [31:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [3:0]  sel_i = 4'h1;
  logic [3:0]  tmr = 4'h0;    // timer overflow pulses
  logic [1:0]  ph = 2'h0;     // crystal and vco phase
  logic        gpo = 1'b0;    // io level
  logic        gpd = 1'b0;    // io drive request
  logic        clr = 1'b0;    // clears the pin edge count
  logic [31:0] dat_o;
  logic        ack_o, pd, pin, oe_n, gpi, slow, line;
  logic [4:0]  fbm;
  logic [7:0]  div, r;
  logic [7:0]  fbt [4] = '{8'h17, 8'h1b, 8'h1c, 8'h17};
  int          n_mismatch = 0, comparisons = 0, edges, pe, se, e1;

  always #2.5 clk_i = ~clk_i;
  // crystal and vco levels, one period every four cycles
  always @(posedge clk_i) ph <= ph + 2'h1;

  pcc_clock_config #(.SLOW_OSC_BASE(2)) i_pcc_clock_config (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .xtal_clk_i(ph[1]), .vco_half_i(ph[1]),
    .timer_overflow_i(tmr), .pll_power_down_o(pd), .feedback_mult_o(fbm),
    .output_divide_factor_o(div), .gpio_out_i(gpo), .gpio_drive_i(gpd),
    .gpio_in_o(gpi), .clock_output_pin_i(line), .clock_output_pin_o(pin),
    .clock_output_pin_oe_n_o(oe_n), .slow_oscillator_o(slow));
  pcc_pin_load i_pcc_pin_load (.clk_i(clk_i), .clr_i(clr), .pin_i(pin),
    .oe_n_i(oe_n), .line_o(line), .edges_o(edges));

  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chn(string nm, int e, int g, int t);
    comparisons++;
    if (g < e - t || g > e + t) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // one classic wishbone cycle
  task wb(logic w, logic [7:0] idx, logic [7:0] wd);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {22'h00_0000, idx, 2'h0};
    dat_i <= {24'h00_0000, wd};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(logic [7:0] idx, logic [7:0] wd);
    wb(1'b1, idx, wd);
  endtask
  task rc(string nm, logic [7:0] idx, logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(nm, e, r);
  endtask
  // counts pin and slow oscillator edges over n cycles
  task run(int n);
    logic s0;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    se = 0;
    s0 = slow;
    repeat (n) begin
      @(posedge clk_i);
      if (slow && !s0) se++;
      s0 = slow;
    end
    pe = edges;
  endtask
  // four overflows of timer c, with the other timers in between
  task pulse(int c);
    repeat (4) begin
      repeat (2) @(posedge clk_i);
      tmr <= ~(4'h1 << c);
      @(posedge clk_i);
      tmr <= 4'h0;
      repeat (2) @(posedge clk_i);
      tmr <= 4'h1 << c;
      @(posedge clk_i);
      tmr <= 4'h0;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    finish_test;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc("trim", 8'h3c, 8'h80);
    rc("ctrl", 8'h3d, 8'h04);
    rc("div", 8'h3e, 8'h08);
    wr(8'h50, 8'h5a);
    rc("unmapped", 8'h50, 8'h00);
    wr(8'h3e, 8'hfe);
    rc("div", 8'h3e, 8'hfe);
    chk("div port", 8'hfe, div);
    for (int c = 0; c < 4; c++) begin
      wr(8'h3d, {6'h01, c[1:0]});
      chk("mult", fbt[c], {3'h0, fbm});
    end
    chk("pd", 8'h01, {7'h0, pd});
    $display("test registers done");
    wr(8'h3d, 8'h28);
    repeat (3) @(posedge clk_i);
    chk("low", 8'h00, {7'h0, line});
    wr(8'h3d, 8'h38);
    repeat (3) @(posedge clk_i);
    chk("high", 8'h01, {7'h0, line});
    gpd <= 1'b1;
    gpo <= 1'b1;
    wr(8'h3d, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("io out", 8'h01, {7'h0, line});
    chk("io in", 8'h01, {7'h0, gpi});
    gpd <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("io oe_n", 8'h01, {7'h0, oe_n});
    $display("test static codes done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h3d, {4'h4 + c[3:0], 4'h8});
      run(256);
      chn("xtal", 64 >> c, pe, 1);
    end
    wr(8'h3d, 8'h40);
    run(256);
    chn("disabled", 0, pe, 0);
    wr(8'h3d, 8'hc8);
    run(256);
    chn("reserved", 0, pe, 0);
    $display("test crystal codes done");
    wr(8'h3e, 8'h08);
    wr(8'h3d, 8'h18);
    chk("pd", 8'h00, {7'h0, pd});
    run(256);
    chn("pll 8", 8, pe, 1);
    wr(8'h3e, 8'h10);
    run(256);
    chn("pll 16", 4, pe, 1);
    wr(8'h3e, 8'h05);
    run(256);
    chn("pll reserved", 0, pe, 0);
    wr(8'h3e, 8'h08);
    wr(8'h3d, 8'h1c);
    run(256);
    chn("pll down", 0, pe, 0);
    $display("test pll done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h3d, {4'h8 + c[3:0], 4'h8});
      fork
        run(64);
        pulse(c);
      join
      chn("timer", 2, pe, 0);
    end
    $display("test timers done");
    wr(8'h3c, 8'h02);
    run(256);
    e1 = se;
    wr(8'h3c, 8'h06);
    run(256);
    chn("slow fast", 32, e1, 1);
    chn("slow slow", 16, se, 1);
    $display("test slow oscillator done");
    finish_test;
  end
endmodule

// >>> verilog/pcc_clock_config.sv
// clock configuration block: slow oscillator trim, two stage pll control
// and the multiplexed clock output pin, behind a classic wishbone slave
// assumes all pin inputs are synchronous to clk_i and the analog pll
// returns its first stage output as a sampled level on vco_half_i
//
// Contract
// RL1: select bits 7:4, codes 0-3 io/pll/low/high
// RL2: codes 4-7 give crystal, /2, /4, /8
// RL3: codes 8-B toggle on timer overflow
// RL4: bit 3 enables the clock on pin
// RL5: bit 2 power down, bits 1:0 feedback
// RL6: feedback factors 23, 27, 28, 23
// RL7: crystal times factor halved, then divided
// RL8: divider ratio 8 to 254, lower reserved
// RL9: larger trim lowers slow oscillator frequency
// RL10: reserved codes hold pin static low
//
// the pin is driven from a flop, so the io path and fixed levels reach it one cycle
// late; the crystal and the first pll stage arrive as sampled levels,
// so their rates must stay below half the rate of clk_i
// a reserved select code or divider value parks the pin low rather
// than let the divider run at a ratio it cannot keep
`timescale 1ns/1ps
`include "pcc_cfg.svh"
module pcc_clock_config #(
  parameter int SLOW_OSC_BASE = 64  // slow oscillator half period base
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // clock sources
  input  wire logic        xtal_clk_i,
  input  wire logic        vco_half_i,
  input  wire logic [3:0]  timer_overflow_i,
  // analog pll controls
  output logic             pll_power_down_o,
  output logic      [4:0]  feedback_mult_o,
  output logic      [7:0]  output_divide_factor_o,
  // general io path of the pin
  input  wire logic        gpio_out_i,
  input  wire logic        gpio_drive_i,
  output logic             gpio_in_o,
  // clock output pin
  input  wire logic        clock_output_pin_i,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_n_o,
  // slow oscillator
  output logic             slow_oscillator_o
);
  // register bits
  pcc_pkg::pcc_byte_t slow_osc_trim;       // trim register
  pcc_pkg::pcc_byte_t pll_control;         // pll control register
  pcc_pkg::pcc_byte_t pll_output_divider;  // output divider register

  // decoded fields
  pcc_pkg::pcc_sel_t  clock_pin_source_select;  // pin source code
  logic               clock_pin_enable;         // clock enable on pin
  logic               pll_power_down;           // pll power down
  logic [1:0]         feedback_divide_code;     // feedback code
  logic               divider_legal;            // divider in range
  logic               source_reserved;          // reserved code in use

  // bus decode
  logic               bus_req;    // a new request waits
  logic               bus_write;  // write strobe this cycle
  logic [7:0]         bus_index;  // register index of the request
  pcc_pkg::pcc_byte_t rd_byte;    // read data before the register

  // clock path state
  logic               xtal_q;       // previous crystal level
  logic [2:0]         xtal_cnt;     // crystal edge counter
  logic               xtal_rise;    // crystal rising edge this cycle
  logic               xtal_level;   // sampled crystal level
  logic [3:0]         timer_tgl;    // timer overflow toggles
  logic               pll_clk;      // divided pll output
  logic               next_pin;     // next pin level
  logic               next_oe_n;    // next pin output enable
  logic               pin_level;    // last driven pin level

  // the slow oscillator counts its half period in ten bits
  generate
    if (SLOW_OSC_BASE < 1 || SLOW_OSC_BASE > 767) begin : g_bad_base
      $error("pcc_clock_config: SLOW_OSC_BASE out of range");
    end
  endgenerate

  // true when the request in flight writes the register at index idx
  function automatic logic write_hit(input logic [7:0] idx);
    write_hit = bus_write && (bus_index == idx);
  endfunction

  // feedback code to multiplication factor
  function automatic pcc_pkg::pcc_mult_t fb_mult(input logic [1:0] code);
    unique case (code)
      2'b00: fb_mult = `PCC_FB_MULT_00;
      2'b01: fb_mult = `PCC_FB_MULT_01;
      2'b10: fb_mult = `PCC_FB_MULT_10;
      2'b11: fb_mult = `PCC_FB_MULT_11;
    endcase
  endfunction

  // field extraction
  assign clock_pin_source_select =
    pll_control[`PCC_SEL_MSB:`PCC_SEL_LSB];               // RL1
  assign clock_pin_enable = pll_control[`PCC_EN_BIT];     // RL4
  assign pll_power_down   = pll_control[`PCC_PD_BIT];     // RL5
  assign feedback_divide_code =
    pll_control[`PCC_FB_MSB:`PCC_FB_LSB];                 // RL5
  // 255 is treated as reserved, like 0 to 7
  assign divider_legal = (pll_output_divider >= `PCC_DIV_MIN) &&
                         (pll_output_divider <= `PCC_DIV_MAX); // RL8
  assign source_reserved =
    (clock_pin_source_select > `PCC_SRC_TIMER_THREE) ||
    ((clock_pin_source_select == `PCC_SRC_PLL) && !divider_legal);

  // analog pll controls
  assign pll_power_down_o       = pll_power_down;
  assign output_divide_factor_o = pll_output_divider;

  // feedback factor held in a flop so the analog side sees a clean code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feedback_mult_o <= `PCC_FB_MULT_00;   // reset control has code 00
    end else begin
      feedback_mult_o <= fb_mult(feedback_divide_code); // RL6
    end
  end

  // bus request decode; ack is registered so a request is one wait state
  assign bus_req   = cyc_i & stb_i & ~ack_o;
  assign bus_write = bus_req & we_i & sel_i[0];
  assign bus_index = adr_i[9:2];

  // wishbone acknowledge, dropped the cycle after it was given
  // a request still up while ack is high is the one just answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // trim register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_osc_trim <= `PCC_RST_TRIM;
    end else if (write_hit(`PCC_IDX_SLOW_OSC_TRIM)) begin
      slow_osc_trim <= dat_i[7:0];
    end
  end

  // pll control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_control <= `PCC_RST_PLL_CONTROL;
    end else if (write_hit(`PCC_IDX_PLL_CONTROL)) begin
      pll_control <= dat_i[7:0];
    end
  end

  // output divider register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_output_divider <= `PCC_RST_OUT_DIVIDER;
    end else if (write_hit(`PCC_IDX_PLL_OUT_DIVIDER)) begin
      pll_output_divider <= dat_i[7:0];
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    unique case (bus_index)
      `PCC_IDX_SLOW_OSC_TRIM:   rd_byte = slow_osc_trim;
      `PCC_IDX_PLL_CONTROL:     rd_byte = pll_control;
      `PCC_IDX_PLL_OUT_DIVIDER: rd_byte = pll_output_divider;
      // status: slow oscillator, pin level, reserved setup in use
      `PCC_IDX_STATUS:          rd_byte = {5'b00000, slow_oscillator_o,
                                           pin_level, source_reserved};
      default:                  rd_byte = 8'h00;
    endcase
  end

  // registered read data, taken with the acknowledge
  // writes leave the last read data standing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // crystal sampling: the pin level and the edge memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_q     <= 1'b0;
      xtal_level <= 1'b0;
    end else begin
      xtal_q     <= xtal_clk_i;
      xtal_level <= xtal_clk_i;
    end
  end

  assign xtal_rise = xtal_clk_i & ~xtal_q;

  // binary division by 2, 4 and 8, stepped on each crystal rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_cnt <= 3'b000;
    end else if (xtal_rise) begin
      xtal_cnt <= xtal_cnt + 3'b001;   // RL2
    end
  end

  // toggle flops flipped by each timer overflow
  // they run whatever the select, so a switch may land on either level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_tgl <= 4'h0;
    end else begin
      timer_tgl <= timer_tgl ^ timer_overflow_i;   // RL3
    end
  end

  // second pll stage: divide the halved vco by the output factor
  pcc_ratio_divider u_out_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (!pll_power_down && divider_legal),
    .ratio_i (pll_output_divider),
    .src_i   (vco_half_i),   // RL7
    .div_o   (pll_clk)
  );

  // trimmable slow oscillator
  pcc_slow_osc #(
    .BASE_HALF (SLOW_OSC_BASE)
  ) u_slow_osc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .trim_i (slow_osc_trim),
    .osc_o  (slow_oscillator_o)
  );

  // pin source selection
  always_comb begin
    // every source but the io path drives the pin
    next_oe_n = 1'b0;
    next_pin  = 1'b0;
    unique case (clock_pin_source_select)
      `PCC_SRC_GPIO: begin
        next_pin  = gpio_out_i;                           // RL1
        next_oe_n = ~gpio_drive_i;
      end
      `PCC_SRC_PLL:       next_pin = pll_clk & divider_legal; // RL10
      `PCC_SRC_LOW:       next_pin = 1'b0;                // RL1
      `PCC_SRC_HIGH:      next_pin = 1'b1;                // RL1
      `PCC_SRC_XTAL:      next_pin = xtal_level;          // RL2
      `PCC_SRC_XTAL_DIV2: next_pin = xtal_cnt[0];         // RL2
      `PCC_SRC_XTAL_DIV4: next_pin = xtal_cnt[1];         // RL2
      `PCC_SRC_XTAL_DIV8: next_pin = xtal_cnt[2];         // RL2
      4'h8, 4'h9, 4'ha, 4'hb: begin
        next_pin = timer_tgl[clock_pin_source_select[1:0]]; // RL3
      end
      default:            next_pin = 1'b0;                // RL10
    endcase
    // clock sources are gated by the enable bit, levels and io are not
    if (!clock_pin_enable &&
        clock_pin_source_select != `PCC_SRC_GPIO &&
        clock_pin_source_select != `PCC_SRC_HIGH) begin
      next_pin = 1'b0;                                    // RL4
    end
  end

  // registered pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_level               <= 1'b0;
      clock_output_pin_oe_n_o <= 1'b1;
    end else begin
      pin_level               <= next_pin;
      clock_output_pin_oe_n_o <= next_oe_n;
    end
  end

  // registered pin input for the general io path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_in_o <= 1'b0;
    end else begin
      gpio_in_o <= clock_output_pin_i;
    end
  end

  // the pin level flop also feeds the status register
  assign clock_output_pin_o = pin_level;
endmodule

// >>> verilog/pcc_ratio_divider.sv
// integer edge divider: divides the rate of a sampled clock level by ratio
// assumes src_i is synchronous to clk_i and below half its rate
`timescale 1ns/1ps
module pcc_ratio_divider (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             run_i,
  input  wire pcc_pkg::pcc_byte_t ratio_i,
  // clock in and out
  input  wire logic             src_i,
  output logic                  div_o
);
  logic                src_q;     // previous source level
  pcc_pkg::pcc_byte_t  edge_cnt;  // rising edges seen in this period
  logic                src_rise;  // source rising edge

  assign src_rise = src_i & ~src_q;

  // edge memory of the source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src_i;
    end
  end

  // count source edges modulo the ratio
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      edge_cnt <= 8'h00;
    end else if (src_rise) begin
      if (edge_cnt >= ratio_i - 8'h01) begin
        edge_cnt <= 8'h00;
      end else begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end

  // high for the first half of each period, low when stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      div_o <= 1'b0;
    end else begin
      div_o <= (edge_cnt < {1'b0, ratio_i[7:1]});
    end
  end
endmodule

// >>> verilog/pcc_slow_osc.sv
// trimmable slow oscillator: the half period grows with the trim value
// assumes clk_i is the only clock; the output is a plain level
`timescale 1ns/1ps
module pcc_slow_osc #(
  parameter int BASE_HALF = 64  // half period in cycles at trim zero
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // trim
  input  wire pcc_pkg::pcc_byte_t trim_i,
  // oscillator level
  output logic                  osc_o
);
  logic [9:0] half_cnt;   // cycles spent in the present half period
  logic [9:0] half_len;   // length of a half period

  generate
    if (BASE_HALF < 1 || BASE_HALF > 767) begin : g_bad
      $error("pcc_slow_osc: BASE_HALF out of range");
    end
  endgenerate

  // larger trim gives a longer period, so a lower frequency
  assign half_len = 10'(BASE_HALF) + {2'b00, trim_i}; // RL9

  // half period counter and output toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_cnt <= 10'h000;
      osc_o    <= 1'b0;
    end else if (half_cnt >= half_len - 10'h001) begin
      half_cnt <= 10'h000;
      osc_o    <= ~osc_o;
    end else begin
      half_cnt <= half_cnt + 10'h001;
    end
  end
endmodule
